// *** hw/sdsm_session.sv ***
// Data session manager: peer tracking, UDP and TCP session rules, retransmit timing.
//
// What this block does
// - Transport select: 0 UDP, 1 TCP.
// - First UDP datagram establishes session, records peer.
// - Source filter drops datagrams from other IPs, except in broadcast mode.
// - Outgoing session opens with datagram to destination.
// - Connect immediately, idle: send zero-length opener.
// - New UDP sender becomes the peer.
// - Server routing follows sender's source port.
// - Other routing modes keep configured destination port under UDP; TCP follows the sender's port.
// - UDP session ends only on timeout.
// - Incoming sessions need server or both role; UDP ones also need filter off.
// - Outgoing sessions need client or both role.
// - All-ones destination IP sends link broadcasts.
// - Broadcast sending keeps the destination IP; server routing follows the sender's port.
// - Broadcast reception gated by its own enable while the source filter is off; with it on, broadcasts are accepted regardless.
// - TCP rejects different IP while established.
// - Same-IP TCP attempt replaces the session.
// - Exactly six equal-interval retransmissions.
// - Interval is period times half second, default six.
// - Passive opens need matching protocol and port.
`timescale 1ns/1ps
`include "sdsm_cfg.svh"
module sdsm_session #(
  parameter int HALF_SEC_CYCLES = `SDSM_HALF_SEC_NS / `SDSM_CLK_NS,
  parameter int TMO_UNIT_CYCLES = `SDSM_HALF_SEC_NS / `SDSM_CLK_NS
) (
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               rx_valid,
  input  wire sdsm_pkg::sdsm_rx_s rx_info,
  output logic                    rx_accept,
  output logic                    rx_drop,
  output logic                    tcp_reject,
  input  wire logic               tx_pending,
  input  wire logic               open_request,
  input  wire logic               tx_ready,
  output logic                    tx_valid,
  output sdsm_pkg::sdsm_tx_s      tx_info,
  input  wire logic               seg_sent,
  input  wire logic               seg_acked,
  output logic                    retx_pulse,
  output logic                    retx_abort,
  output logic                    session_active
);
  import sdsm_pkg::*;

  sdsm_ctrl_s  ctrl;
  logic [31:0] dest_ip;
  logic [15:0] dest_port;
  logic [15:0] local_port;
  logic [15:0] timeout_units;
  logic [31:0] peer_ip;
  logic [15:0] peer_port;
  logic        peer_valid;
  sdsm_state_e state;
  logic        bus_ack;
  logic        rx_is_bcast_mode;
  logic        passive_ok;
  logic        udp_take;
  logic        tcp_take;
  logic        rx_filtered;
  logic        session_timeout;
  logic        timeout_hit;
  logic [31:0] idle_cnt;
  logic [31:0] half_cnt;
  logic [7:0]  retx_ticks;
  logic        half_tick;
  logic        retx_run;
  logic [2:0]  retx_left;
  logic        retx_due;
  logic [31:0] next_peer_ip;
  logic [15:0] next_peer_port;

  assign rx_is_bcast_mode = (dest_ip == `SDSM_BCAST_IP);

  // Avalon slave answers every access one cycle after it is raised.
  // The wait flag is its own flop so the port comes straight from a register.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_ack         <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      bus_ack         <= (avs_read || avs_write) && !bus_ack;
      avs_waitrequest <= !((avs_read || avs_write) && !bus_ack);
    end
  end

  // The control word leaves a gap below the period field, so a plain cast of the
  // word onto the packed struct would shift the period; fields are placed by name.
  function automatic sdsm_ctrl_s ctrl_of(input logic [15:0] w);
    sdsm_ctrl_s c;
    c.rp           = w[15:8];
    c.bcast_rx     = w[5];
    c.src_filter   = w[4];
    c.cm_immediate = w[3];
    c.rm           = w[2:1];
    c.tp           = w[0];
    return c;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl          <= ctrl_of(16'(`SDSM_CTRL_RST));
      dest_ip       <= `SDSM_BCAST_IP;
      dest_port     <= `SDSM_DEST_PORT_RST;
      local_port    <= `SDSM_LOCAL_PORT_RST;
      timeout_units <= `SDSM_TIMEOUT_RST;
    end else if (avs_write && bus_ack) begin
      case (avs_address)
        `SDSM_REG_CTRL:       ctrl <= ctrl_of(avs_writedata[15:0]);
        `SDSM_REG_DEST_IP:    dest_ip <= avs_writedata;
        `SDSM_REG_DEST_PORT:  dest_port <= avs_writedata[15:0];
        `SDSM_REG_LOCAL_PORT: local_port <= avs_writedata[15:0];
        `SDSM_REG_TIMEOUT:    timeout_units <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      case (avs_address)
        `SDSM_REG_CTRL:       avs_readdata <= {16'h0000, ctrl.rp, 2'h0, ctrl.bcast_rx, ctrl.src_filter,
                                               ctrl.cm_immediate, ctrl.rm, ctrl.tp};
        `SDSM_REG_DEST_IP:    avs_readdata <= dest_ip;
        `SDSM_REG_DEST_PORT:  avs_readdata <= {16'h0000, dest_port};
        `SDSM_REG_LOCAL_PORT: avs_readdata <= {16'h0000, local_port};
        `SDSM_REG_TIMEOUT:    avs_readdata <= {16'h0000, timeout_units};
        `SDSM_REG_STATUS:     avs_readdata <= {24'h000000, retx_left, retx_run, 2'h0, state};
        `SDSM_REG_PEER_IP:    avs_readdata <= peer_ip;
        `SDSM_REG_PEER_PORT:  avs_readdata <= {15'h0000, peer_valid, peer_port};
        default:              avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    passive_ok = (rx_info.is_tcp == ctrl.tp) && (rx_info.dst_port == local_port);
    rx_filtered = ctrl.src_filter && !rx_is_bcast_mode && (rx_info.src_ip != dest_ip);
    udp_take = rx_valid && passive_ok && (ctrl.tp == `SDSM_TP_UDP) && !rx_filtered
               && (ctrl.rm != `SDSM_RM_CLIENT) && !ctrl.src_filter
               && (!rx_info.is_bcast || ctrl.bcast_rx);
    tcp_take = rx_valid && passive_ok && (ctrl.tp == `SDSM_TP_TCP) && rx_info.is_syn
               && (ctrl.rm != `SDSM_RM_CLIENT)
               && (!peer_valid || rx_info.src_ip == peer_ip);
    next_peer_port = (ctrl.rm == `SDSM_RM_SERVER) ? rx_info.src_port : dest_port;
    next_peer_ip   = rx_info.src_ip;
  end

  // Datagrams passing the source filter are accepted but neither record the peer nor clear the idle count.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_accept  <= 1'b0;
      rx_drop    <= 1'b0;
      tcp_reject <= 1'b0;
    end else begin
      rx_accept  <= udp_take || tcp_take
                    || (rx_valid && passive_ok && ctrl.src_filter && !rx_filtered && !ctrl.tp);
      // A refused connection attempt is reported as a reject only, never also as a drop.
      rx_drop    <= rx_valid && !(udp_take || tcp_take)
                    && !(passive_ok && ctrl.src_filter && !rx_filtered && !ctrl.tp)
                    && !(passive_ok && ctrl.tp && rx_info.is_syn);
      tcp_reject <= rx_valid && passive_ok && ctrl.tp && rx_info.is_syn && !tcp_take;
    end
  end

  // Timeout of zero disables expiry; counter clears on every taken UDP datagram and while a datagram is offered.
  always_ff @(posedge sys_clk) begin
    if (srst || !peer_valid || udp_take || tx_valid) begin
      idle_cnt <= 32'h0000_0000;
    end else if (!timeout_hit) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end
  always_comb begin
    timeout_hit = (timeout_units != `SDSM_TIMEOUT_RST)
                  && (idle_cnt >= 32'(timeout_units) * 32'(TMO_UNIT_CYCLES));
    session_timeout = peer_valid && (ctrl.tp == `SDSM_TP_UDP) && timeout_hit;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      peer_ip    <= 32'h0000_0000;
      peer_port  <= 16'h0000;
      peer_valid <= 1'b0;
    end else if (udp_take || tcp_take) begin
      peer_ip    <= next_peer_ip;
      peer_port  <= ctrl.tp ? rx_info.src_port : next_peer_port;
      peer_valid <= 1'b1;
    end else if (state == SDSM_OPEN && tx_valid && tx_ready) begin
      peer_ip    <= dest_ip;
      peer_port  <= dest_port;
      peer_valid <= 1'b1;
    end else if (session_timeout) begin
      peer_valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= SDSM_IDLE;
    end else begin
      case (state)
        SDSM_IDLE: begin
          if (peer_valid) begin
            state <= SDSM_RUN;
          end else if (ctrl.tp == `SDSM_TP_UDP && ctrl.rm != `SDSM_RM_SERVER
                       && (tx_pending || open_request || ctrl.cm_immediate)) begin
            state <= SDSM_OPEN;
          end
        end
        SDSM_OPEN: begin
          // The open completes only when the host has really taken the opener.
          if (tx_valid && tx_ready) begin
            state <= SDSM_RUN;
          end
        end
        SDSM_RUN: begin
          if (!peer_valid) begin
            state <= SDSM_IDLE;
          end
        end
        default: state <= SDSM_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_info  <= '0;
    end else begin
      // A datagram stays offered until the host takes it, then drops for one cycle.
      // Data datagrams of a running UDP session share the same descriptor path.
      tx_valid <= tx_valid ? !tx_ready
                           : (state == SDSM_OPEN || (state == SDSM_RUN && ctrl.tp == `SDSM_TP_UDP && tx_pending));
      tx_info.zero_len <= !tx_pending && ctrl.cm_immediate;
      tx_info.bcast    <= rx_is_bcast_mode;
      tx_info.dst_mac  <= rx_is_bcast_mode ? `SDSM_BCAST_MAC : 48'h0000_0000_0000;
      tx_info.dst_ip   <= (rx_is_bcast_mode || !peer_valid) ? dest_ip : peer_ip;
      tx_info.dst_port <= (!peer_valid || (ctrl.rm != `SDSM_RM_SERVER && !ctrl.tp)) ? dest_port : peer_port;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      session_active <= 1'b0;
    end else begin
      session_active <= peer_valid && (ctrl.tp == `SDSM_TP_TCP || ctrl.tp == `SDSM_TP_UDP);
    end
  end

  // An interval ends once the full period of half-second ticks has elapsed.
  assign retx_due = retx_run && half_tick && (retx_ticks >= ctrl.rp);

  // Half-second ticks times period.
  // The half-second counter runs on across an expiry and only the tick count
  // restarts, so every interval is exactly period times half a second long.
  always_ff @(posedge sys_clk) begin
    if (srst || !retx_run || seg_sent) begin
      half_cnt   <= 32'h0000_0000;
      retx_ticks <= 8'h00;
      half_tick  <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (half_cnt == 32'(HALF_SEC_CYCLES - 1)) begin
        half_cnt   <= 32'h0000_0000;
        retx_ticks <= retx_due ? 8'h01 : retx_ticks + 8'h01;
        half_tick  <= 1'b1;
      end else begin
        half_cnt <= half_cnt + 32'h0000_0001;
        if (retx_due) begin
          retx_ticks <= 8'h00;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      retx_run   <= 1'b0;
      retx_left  <= 3'h0;
      retx_pulse <= 1'b0;
      retx_abort <= 1'b0;
    end else begin
      retx_pulse <= 1'b0;
      retx_abort <= 1'b0;
      if (seg_acked) begin
        retx_run <= 1'b0;
      end else if (seg_sent) begin
        retx_run  <= 1'b1;
        retx_left <= `SDSM_RETRIES;
      end else if (retx_due) begin
        if (retx_left == 3'h0) begin
          retx_run   <= 1'b0;
          retx_abort <= 1'b1;
        end else begin
          retx_pulse <= 1'b1;
          retx_left  <= retx_left - 3'h1;
        end
      end
    end
  end
endmodule

// *** inc/sdsm_cfg.svh ***
// Configuration constants of the data session manager.
`ifndef SDSM_CFG_SVH
`define SDSM_CFG_SVH
`define SDSM_REG_CTRL        4'h0
`define SDSM_REG_DEST_IP     4'h1
`define SDSM_REG_DEST_PORT   4'h2
`define SDSM_REG_LOCAL_PORT  4'h3
`define SDSM_REG_TIMEOUT     4'h4
`define SDSM_REG_STATUS      4'h5
`define SDSM_REG_PEER_IP     4'h6
`define SDSM_REG_PEER_PORT   4'h7
`define SDSM_CTRL_RST        32'h0000_0600
`define SDSM_TP_UDP          1'b0
`define SDSM_TP_TCP          1'b1
`define SDSM_RM_SERVER       2'h0
`define SDSM_RM_BOTH         2'h1
`define SDSM_RM_CLIENT       2'h2
`define SDSM_RP_DEFAULT      8'h06
`define SDSM_RETRIES         3'h6
`define SDSM_HALF_SEC_NS     500000000
`define SDSM_CLK_NS          4
`define SDSM_BCAST_IP        32'hffff_ffff
`define SDSM_BCAST_MAC       48'hffff_ffff_ffff
`define SDSM_DEST_PORT_RST   16'h0000
`define SDSM_LOCAL_PORT_RST  16'h03e9
`define SDSM_TIMEOUT_RST     16'h0000
`endif

// *** inc/sdsm_pkg.sv ***
// Types shared by the data session manager.
package sdsm_pkg;
  typedef struct packed {
    logic        is_tcp;
    logic        is_syn;
    logic        is_bcast;
    logic [31:0] src_ip;
    logic [15:0] src_port;
    logic [15:0] dst_port;
  } sdsm_rx_s;
  typedef struct packed {
    logic        zero_len;
    logic        bcast;
    logic [47:0] dst_mac;
    logic [31:0] dst_ip;
    logic [15:0] dst_port;
  } sdsm_tx_s;
  typedef struct packed {
    logic [7:0]  rp;
    logic        bcast_rx;
    logic        src_filter;
    logic        cm_immediate;
    logic [1:0]  rm;
    logic        tp;
  } sdsm_ctrl_s;
  typedef enum logic [1:0] {SDSM_IDLE, SDSM_OPEN, SDSM_RUN} sdsm_state_e;
endpackage

// *** test/sdsm_session_asserts.sv ***
// Port-level assertions for the data session manager.
`timescale 1ns/1ps
`include "sdsm_cfg.svh"
module sdsm_session_asserts (
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic               rx_valid,
  input wire sdsm_pkg::sdsm_rx_s rx_info,
  input wire logic               rx_accept,
  input wire logic               rx_drop,
  input wire logic               tcp_reject,
  input wire logic               tx_pending,
  input wire logic               tx_valid,
  input wire sdsm_pkg::sdsm_tx_s tx_info,
  input wire logic               retx_pulse,
  input wire logic               retx_abort
);
  import sdsm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rx_one; rx_valid |=> $onehot({rx_accept, rx_drop, tcp_reject}); endproperty
  a_rx_one: assert property (p_rx_one) else $error("datagram without single verdict");
  property p_rx_quiet; !rx_valid |=> !(rx_accept || rx_drop || tcp_reject); endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("verdict without datagram");
  property p_rej; tcp_reject |-> $past(rx_valid && rx_info.is_tcp && rx_info.is_syn); endproperty
  a_rej: assert property (p_rej) else $error("reject without connection attempt");
  property p_bc; tx_valid && tx_info.dst_ip == `SDSM_BCAST_IP |-> tx_info.bcast && tx_info.dst_mac == `SDSM_BCAST_MAC;
  endproperty
  a_bc: assert property (p_bc) else $error("all-ones address not broadcast");
  property p_zl; tx_valid && tx_info.zero_len |-> !$past(tx_pending); endproperty
  a_zl: assert property (p_zl) else $error("empty opener while data waits");
  property p_ws; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_ws: assert property (p_ws) else $error("bus answer late");
  property p_wl; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wl: assert property (p_wl) else $error("answer longer than one cycle");
  property p_ab; retx_abort |=> !retx_pulse [*8]; endproperty
  a_ab: assert property (p_ab) else $error("retransmit after abort");
  c_acc: cover property (rx_accept);
  c_rej: cover property (tcp_reject);
  c_ab: cover property (retx_abort);
endmodule
bind sdsm_session sdsm_session_asserts sdsm_session_asserts_i (.sys_clk, .srst, .avs_read, .avs_write,
  .avs_waitrequest, .rx_valid, .rx_info, .rx_accept, .rx_drop, .tcp_reject, .tx_pending, .tx_valid,
  .tx_info, .retx_pulse, .retx_abort);

// *** test/sdsm_host_model.sv ***
// Remote network host: offers datagrams and takes the device's transmissions.
`timescale 1ns/1ps
module sdsm_host_model (
  input  wire logic               sys_clk,
  output logic                    rx_valid,
  output sdsm_pkg::sdsm_rx_s      rx_info,
  output logic                    tx_ready,
  input  wire logic               tx_valid,
  input  wire sdsm_pkg::sdsm_tx_s tx_info
);
  import sdsm_pkg::*;
  logic     stall = 1'b0;
  int       n_tx = 0;
  sdsm_tx_s last_tx;
  initial begin
    rx_valid = 1'b0;
    rx_info = '0;
    tx_ready = 1'b1;
  end
  // A stalled host takes only every other cycle, to exercise slow acceptance.
  always @(posedge sys_clk) tx_ready <= !stall || !tx_ready;
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      last_tx <= tx_info;
      n_tx <= n_tx + 1;
    end
  end
  // Released descriptor lines show the inverse so stale values cannot pass.
  task automatic send(input sdsm_rx_s d);
    rx_info <= d;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_info <= ~d;
    @(posedge sys_clk);
  endtask
endmodule

// *** test/sdsm_session_bench.sv ***
// Self-checking bench for the data session manager.
`timescale 1ns/1ps
module sdsm_session_bench;
  import sdsm_pkg::*;
  localparam int HS = 10;
  localparam logic [31:0] IPA = 32'h0a00_0001;
  localparam logic [31:0] IPB = 32'h0a00_0002;
  localparam logic [15:0] LP = 16'h03e9;
  logic        sys_clk, srst, avs_read, avs_write, avs_waitrequest, rx_valid, rx_accept, rx_drop, tcp_reject;
  logic        tx_pending, open_request, tx_ready, tx_valid, seg_sent, seg_acked, retx_pulse, retx_abort;
  logic        session_active;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  sdsm_rx_s    rx_info;
  sdsm_tx_s    tx_info;
  int          n_mismatch = 0, checks = 0, np, last, k, k0;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  sdsm_session #(.HALF_SEC_CYCLES(HS), .TMO_UNIT_CYCLES(HS)) sdsm_session_i (.sys_clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_valid, .rx_info, .rx_accept,
    .rx_drop, .tcp_reject, .tx_pending, .open_request, .tx_ready, .tx_valid, .tx_info, .seg_sent,
    .seg_acked, .retx_pulse, .retx_abort, .session_active);
  sdsm_host_model sdsm_host_model_i (.sys_clk, .rx_valid, .rx_info, .tx_ready, .tx_valid, .tx_info);
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) n_mismatch++;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q, e);
  endtask
  function automatic logic [31:0] cw(input logic [7:0] rp, input logic [5:0] f);
    return {16'h0000, rp, 2'h0, f};
  endfunction
  task automatic rx(input logic [2:0] t, input logic [31:0] ip, input logic [15:0] sp, dp, input logic [2:0] e);
    sdsm_host_model_i.send({t, ip, sp, dp});
    cmp({rx_accept, rx_drop, tcp_reject}, e);
  endtask
  task automatic wtx(input int n0);
    k = 0;
    while (sdsm_host_model_i.n_tx == n0 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 200) n_mismatch++;
  endtask
  task automatic rst;
    srst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic pulse_seg(input logic ack);
    if (ack) seg_acked <= 1'b1; else seg_sent <= 1'b1;
    @(posedge sys_clk);
    seg_acked <= 1'b0;
    seg_sent <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    tx_pending = 1'b0;
    open_request = 1'b0;
    seg_sent = 1'b0;
    seg_acked = 1'b0;
    rst;
    rd(4'h0, 32'h0000_0600);
    rd(4'h1, 32'hffff_ffff);
    rd(4'h3, 32'h0000_03e9);
    rd(4'h7, 32'h0);
    wr(4'h6, IPA);
    rd(4'h6, 32'h0);
    wr(4'h8, IPA);
    rd(4'h8, 32'h0);
    k0 = sdsm_host_model_i.n_tx;
    wr(4'h0, cw(8'h06, 6'h28));
    repeat (10) @(posedge sys_clk);
    cmp(sdsm_host_model_i.n_tx, k0);
    $display("test registers done");
    wr(4'h0, cw(8'h06, 6'h20));
    wr(4'h1, IPA);
    wr(4'h2, 32'h0000_5555);
    rx(3'h0, IPA, 16'h1111, LP, 3'h4);
    rd(4'h7, 32'h0001_1111);
    rx(3'h0, IPB, 16'h2222, LP, 3'h4);
    rd(4'h6, IPB);
    rd(4'h7, 32'h0001_2222);
    rx(3'h0, IPA, 16'h1111, 16'h0400, 3'h2);
    rx(3'h6, IPA, 16'h1111, LP, 3'h2);
    wr(4'h0, cw(8'h06, 6'h22));
    rx(3'h0, IPA, 16'h3333, LP, 3'h4);
    rd(4'h7, 32'h0001_5555);
    $display("test udp_server done");
    rst;
    k0 = sdsm_host_model_i.n_tx;
    wr(4'h2, 32'h0000_5555);
    wr(4'h1, IPA);
    wr(4'h0, cw(8'h06, 6'h2c));
    wtx(k0);
    cmp({sdsm_host_model_i.last_tx.zero_len, sdsm_host_model_i.last_tx.dst_ip}, {1'b1, IPA});
    cmp(sdsm_host_model_i.last_tx.dst_port, 16'h5555);
    $display("test udp_open done");
    rst;
    sdsm_host_model_i.stall <= 1'b1;
    k0 = sdsm_host_model_i.n_tx;
    wr(4'h0, cw(8'h06, 6'h22));
    open_request <= 1'b1;
    wtx(k0);
    open_request <= 1'b0;
    cmp({sdsm_host_model_i.last_tx.bcast, sdsm_host_model_i.last_tx.dst_mac}, {1'b1, 48'hffff_ffff_ffff});
    rx(3'h0, IPA, 16'h1111, LP, 3'h4);
    k0 = sdsm_host_model_i.n_tx;
    tx_pending <= 1'b1;
    wtx(k0);
    tx_pending <= 1'b0;
    cmp({sdsm_host_model_i.last_tx.zero_len, sdsm_host_model_i.last_tx.dst_ip}, {1'b0, 32'hffff_ffff});
    sdsm_host_model_i.stall <= 1'b0;
    $display("test broadcast done");
    rst;
    wr(4'h1, IPA);
    wr(4'h0, cw(8'h06, 6'h30));
    rx(3'h0, IPB, 16'h1111, LP, 3'h2);
    rx(3'h0, IPA, 16'h1111, LP, 3'h4);
    wr(4'h0, cw(8'h06, 6'h00));
    rx(3'h1, IPA, 16'h1111, LP, 3'h2);
    wr(4'h0, cw(8'h06, 6'h20));
    rx(3'h1, IPA, 16'h1111, LP, 3'h4);
    $display("test filters done");
    rst;
    wr(4'h0, cw(8'h02, 6'h21));
    rx(3'h6, IPA, 16'h1111, LP, 3'h4);
    rx(3'h6, IPB, 16'h2222, LP, 3'h1);
    rx(3'h6, IPA, 16'h1112, LP, 3'h4);
    rd(4'h6, IPA);
    pulse_seg(1'b0);
    np = 0;
    last = 0;
    k = 0;
    while (retx_abort !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      k++;
      if (retx_pulse === 1'b1) begin
        if (np > 0) cmp(k - last, 2 * HS);
        np++;
        last = k;
      end
    end
    cmp(np, 6);
    pulse_seg(1'b0);
    repeat (5) @(posedge sys_clk);
    pulse_seg(1'b1);
    np = 0;
    repeat (100) @(posedge sys_clk) if (retx_pulse === 1'b1) np++;
    cmp(np, 0);
    $display("test tcp done");
    rst;
    wr(4'h4, 32'h1);
    wr(4'h0, cw(8'h06, 6'h20));
    rx(3'h0, IPA, 16'h1111, LP, 3'h4);
    @(posedge sys_clk);
    cmp(session_active, 1'b1);
    repeat (60) @(posedge sys_clk);
    cmp(session_active, 1'b0);
    $display("test timeout done");
    end_sim;
  end
endmodule
